// ---- rtl/cache_clock_config_regs.svh ----
`ifndef CACHE_CLOCK_CONFIG_REGS_SVH
`define CACHE_CLOCK_CONFIG_REGS_SVH

// Register indices on the register port
`define ADDR_WIDTH          4
`define OFS_CACHE_SETUP     4'h4
`define OFS_POWERUP_SELECT  4'h5
`define OFS_BUS_CLOCK_SRC   4'h6
`define OFS_SLEEP_CONTROL   4'h8
`define OFS_UNCACHED_RANGE  4'h9

// Reset values
`define RST_CACHE_SETUP     8'h00
`define RST_POWERUP_SELECT  8'h00
`define RST_BUS_CLOCK_SRC   8'h00
`define RST_SLEEP_CONTROL   8'h00
`define RST_UNCACHED_RANGE  8'h00

// Writable bit masks, everything else reads zero except power-up bits 7-5 (straps)
`define MASK_CACHE_SETUP    8'hFF
`define MASK_POWERUP_SELECT 8'h0B
`define MASK_BUS_CLOCK_SRC  8'hFF
`define MASK_SLEEP_CONTROL  8'h0F
`define MASK_UNCACHED_RANGE 8'hF2

// Field positions
`define CACHE_POST_WRITE    7
`define CACHE_WRITE_0WAIT   6
`define CACHE_READ_1WAIT    5
`define CACHE_DRAM_BURST    4
`define CACHE_FILL_BURST    3
`define CACHE_LINE_HI       2
`define CACHE_LINE_LO       1
`define CACHE_ENABLE        0
`define PU_ROM_8BIT         7
`define PU_OLDER_CPU        6
`define PU_L1_WRITE_BACK    5
`define PU_UPPER_ROM_SYS    3
`define SRC_SEL_HI          4
`define SRC_SEL_LO          3
`define SLEEP_ENABLE        3
`define RANGE_BASE_512K     1

// Timing counts
`define STRAP_SETTLE_CYCLES 3'h4
`define CRYSTAL_HALF_COUNT  4'h2
// Alt half periods per delay tick or per bus clock half period, one nibble per code, code 0 lowest
`define DELAY_HALF_TABLE    32'h842253A6
`define BUS_ALT_HALF_TABLE  32'h4282356A
// Sleep divisors, one byte per code, code 0 lowest
`define SLEEP_DIV_TABLE     64'h1008040280402001

`endif

// ---- rtl/cache_clock_config_pkg.sv ----
package cache_clock_config_pkg;

	typedef enum logic [1:0] {LINE_32, LINE_64, LINE_128} line_size_type;

	typedef enum logic [2:0] {
		NC_NONE, NC_ABOVE_32M, NC_ABOVE_16M, NC_ABOVE_8M, NC_ABOVE_4M
	} nc_limit_type;

	typedef enum logic [1:0] {SRC_14M, SRC_24M, SRC_ALT} clk_src_type;

	typedef struct packed {
		logic          post_write_en;
		logic          page_write_zero_wait;
		logic          cache_read_one_wait;
		logic          dram_burst_en;
		logic          cache_fill_burst_en;
		line_size_type line_size;
		logic          cache_en;
	} cache_cfg_type;

	typedef struct packed {
		nc_limit_type nc_limit;
		logic         base_512k;
		logic         upper_rom_from_system_bus;
		logic [3:0]   refresh_div;
	} mem_cfg_type;

	typedef struct packed {
		logic rom_8bit;
		logic older_cpu_mode;
		logic l1_write_back;
	} strap_type;

endpackage

// ---- rtl/chipset_cache_clock_config.sv ----
`timescale 1ns/1ps
`include "cache_clock_config_regs.svh"
// Functional notes
// - Cache setup bit 7 enables posted memory writes; resets to zero.
// - Cache setup bit 6: page-hit uncached writes zero wait (1) or one wait.
// - Cache setup bit 5: cache reads one wait when set, zero when clear.
// - Cache setup bit 4 enables DRAM read bursts.
// - Cache setup bit 3 enables external cache burst fill of internal cache.
// - Cache setup bits 2-1: 00/10 line 32, 01 line 64, 11 line 128.
// - Cache setup bit 0 enables cache controller; off after reset.
// - Power-up bit 7 read-only: one for 8-bit boot ROM, zero 16-bit.
// - Power-up bit 6 read-only: one older processor mode, zero newer.
// - Power-up bit 5 read-only: zero write-through L1, one write-back L1.
// - Power-up bit 3 routes upper ROM reads from system data bus.
// - Power-up bits 1-0 slow refresh divisor 1,2,4,8; software sets them.
// - With external select set, bits 7-5 divide alt source for delay time.
// - Expansion bus clock runs at half the selected crystal frequency.
// - Bit 4 zero selects 14.318 MHz crystal; bits 4,3 one select 24 MHz.
// - Bit 4 one, bit 3 zero: bits 2-0 divide the alternate source.
// - Sleep bit 3 switches system clock to the divided bus clock.
// - Sleep bits 2-0 divide bus clock source by 1,32,64,128,2,4,8,16.
// - Range bits 7-4 mark addresses above 32/16/8/4Mb non-cacheable.
// - Range bit 1 selects 512K base memory, else 640K.
module chipset_cache_clock_config (
	// Clock and reset
	input  wire logic                                  core_clk,
	input  wire logic                                  rst_n,
	// Register port
	input  wire logic [`ADDR_WIDTH-1:0]                reg_addr,
	input  wire logic [7:0]                            reg_wdata,
	input  wire logic                                  reg_wr,
	input  wire logic                                  reg_rd,
	output logic      [7:0]                            reg_rdata_q,
	// Pins
	input  wire logic                                  crystal_14m_input,
	input  wire logic                                  crystal_24m_input,
	input  wire logic                                  alt_clock_source_input,
	input  wire logic                                  strap_rom_8bit,
	input  wire logic                                  strap_older_cpu_mode,
	input  wire logic                                  strap_l1_write_back,
	// Delay clock select from the neighbouring register
	input  wire logic                                  delay_clock_sel,
	// Decoded configuration
	output cache_clock_config_pkg::cache_cfg_type      cache_cfg_q,
	output cache_clock_config_pkg::mem_cfg_type        mem_cfg_q,
	output cache_clock_config_pkg::strap_type          strap_q,
	output cache_clock_config_pkg::clk_src_type        bus_src_sel_q,
	// Derived clocks and ticks
	output logic                                       bus_clk_q,
	output logic                                       sys_clock_q,
	output logic                                       delay_tick_q
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	localparam int PINS = 6;
	localparam int P14  = 0;
	localparam int P24  = 1;
	localparam int PALT = 2;
	typedef enum logic {STRAP_SETTLE, STRAP_HELD} strap_state_type;
	logic [7:0]      cache_q;
	logic [7:0]      pu_q;
	logic [7:0]      src_q;
	logic [7:0]      sleep_q;
	logic [7:0]      range_q;
	logic [PINS-1:0] pin_in;
	logic [PINS-1:0] sync1_q;
	logic [PINS-1:0] sync2_q;
	logic [PINS-1:0] sync3_q;
	logic [PINS-1:0] lvl_q;
	logic [PINS-1:0] half_edge;
	logic [PINS-1:0] settled;
	strap_state_type strap_state_q;
	logic [2:0]      settle_cnt_q;
	logic [3:0]      delay_cnt_q;
	logic [3:0]      delay_limit;
	logic [3:0]      bus_cnt_q;
	logic [3:0]      bus_limit;
	logic            bus_half;
	logic            bus_src_tick;
	logic [7:0]      sleep_cnt_q;
	logic [7:0]      sleep_div;
	logic            sleep_clk_q;
	logic [7:0]      read_mux;
	logic            wr_cache;
	logic            wr_pu;
	logic            wr_src;
	logic            wr_sleep;
	logic            wr_range;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Register writes

	assign wr_cache = reg_wr && reg_addr == `OFS_CACHE_SETUP;
	assign wr_pu    = reg_wr && reg_addr == `OFS_POWERUP_SELECT;
	assign wr_src   = reg_wr && reg_addr == `OFS_BUS_CLOCK_SRC;
	assign wr_sleep = reg_wr && reg_addr == `OFS_SLEEP_CONTROL;
	assign wr_range = reg_wr && reg_addr == `OFS_UNCACHED_RANGE;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cache_q <= `RST_CACHE_SETUP;
		end else if (wr_cache) begin
			cache_q <= reg_wdata & `MASK_CACHE_SETUP;
		end
	end

	// Strap bits are not stored here, reserved bits masked
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pu_q <= `RST_POWERUP_SELECT;
		end else if (wr_pu) begin
			pu_q <= reg_wdata & `MASK_POWERUP_SELECT;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_q <= `RST_BUS_CLOCK_SRC;
		end else if (wr_src) begin
			src_q <= reg_wdata & `MASK_BUS_CLOCK_SRC;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_q <= `RST_SLEEP_CONTROL;
		end else if (wr_sleep) begin
			sleep_q <= reg_wdata & `MASK_SLEEP_CONTROL;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			range_q <= `RST_UNCACHED_RANGE;
		end else if (wr_range) begin
			range_q <= reg_wdata & `MASK_UNCACHED_RANGE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads, data one cycle after the strobe

	always_comb begin
		case (reg_addr)
			`OFS_CACHE_SETUP:    read_mux = cache_q;
			`OFS_POWERUP_SELECT: read_mux = pu_q | {strap_q, 5'h00};
			`OFS_BUS_CLOCK_SRC:  read_mux = src_q;
			`OFS_SLEEP_CONTROL:  read_mux = sleep_q;
			`OFS_UNCACHED_RANGE: read_mux = range_q;
			default:             read_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= read_mux;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and half-period edge detection

	assign pin_in = {strap_rom_8bit, strap_older_cpu_mode, strap_l1_write_back,
		alt_clock_source_input, crystal_24m_input, crystal_14m_input};

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++) begin : g_sync
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					lvl_q[gi]   <= 1'b0;
				end else begin
					sync1_q[gi] <= pin_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (settled[gi]) begin
						lvl_q[gi] <= sync3_q[gi];
					end
				end
			end
			assign settled[gi]   = sync2_q[gi] == sync3_q[gi];
			assign half_edge[gi] = settled[gi] && sync3_q[gi] != lvl_q[gi];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Strap capture after reset release, held until next reset

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_state_q <= STRAP_SETTLE;
			settle_cnt_q  <= 3'h0;
			strap_q       <= '0;
		end else begin
			case (strap_state_q)
				STRAP_SETTLE: begin
					if (settle_cnt_q == `STRAP_SETTLE_CYCLES) begin
						strap_q       <= lvl_q[5:3];
						strap_state_q <= STRAP_HELD;
					end else begin
						settle_cnt_q <= settle_cnt_q + 3'h1;
					end
				end
				STRAP_HELD: strap_q <= strap_q;
				default: strap_state_q <= STRAP_SETTLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded configuration outputs

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cache_cfg_q <= '0;
		end else begin
			cache_cfg_q.post_write_en        <= cache_q[`CACHE_POST_WRITE];
			cache_cfg_q.page_write_zero_wait <= cache_q[`CACHE_WRITE_0WAIT];
			cache_cfg_q.cache_read_one_wait  <= cache_q[`CACHE_READ_1WAIT];
			cache_cfg_q.dram_burst_en        <= cache_q[`CACHE_DRAM_BURST];
			cache_cfg_q.cache_fill_burst_en  <= cache_q[`CACHE_FILL_BURST];
			cache_cfg_q.cache_en             <= cache_q[`CACHE_ENABLE];
			case (cache_q[`CACHE_LINE_HI:`CACHE_LINE_LO])
				2'h1:    cache_cfg_q.line_size <= cache_clock_config_pkg::LINE_64;
				2'h3:    cache_cfg_q.line_size <= cache_clock_config_pkg::LINE_128;
				default: cache_cfg_q.line_size <= cache_clock_config_pkg::LINE_32;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_cfg_q <= '0;
		end else begin
			mem_cfg_q.upper_rom_from_system_bus <= pu_q[`PU_UPPER_ROM_SYS];
			mem_cfg_q.refresh_div <= 4'h1 << pu_q[1:0];
			mem_cfg_q.base_512k   <= range_q[`RANGE_BASE_512K];
			case (range_q[7:4])
				4'h8:    mem_cfg_q.nc_limit <= cache_clock_config_pkg::NC_ABOVE_32M;
				4'hC:    mem_cfg_q.nc_limit <= cache_clock_config_pkg::NC_ABOVE_16M;
				4'hE:    mem_cfg_q.nc_limit <= cache_clock_config_pkg::NC_ABOVE_8M;
				4'hF:    mem_cfg_q.nc_limit <= cache_clock_config_pkg::NC_ABOVE_4M;
				default: mem_cfg_q.nc_limit <= cache_clock_config_pkg::NC_NONE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_src_sel_q <= cache_clock_config_pkg::SRC_14M;
		end else if (!src_q[`SRC_SEL_HI]) begin
			bus_src_sel_q <= cache_clock_config_pkg::SRC_14M;
		end else if (src_q[`SRC_SEL_LO]) begin
			bus_src_sel_q <= cache_clock_config_pkg::SRC_24M;
		end else begin
			bus_src_sel_q <= cache_clock_config_pkg::SRC_ALT;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Digital delay tick from the alternate source

	assign delay_limit = 4'(`DELAY_HALF_TABLE >> {src_q[7:5], 2'h0});
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			delay_cnt_q  <= 4'h0;
			delay_tick_q <= 1'b0;
		end else begin
			delay_tick_q <= 1'b0;
			if (!delay_clock_sel) begin
				delay_cnt_q <= 4'h0;
			end else if (half_edge[PALT]) begin
				if (delay_cnt_q >= delay_limit - 4'h1) begin
					delay_cnt_q  <= 4'h0;
					delay_tick_q <= 1'b1;
				end else begin
					delay_cnt_q <= delay_cnt_q + 4'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expansion bus source divider and bus clock

	always_comb begin
		case (bus_src_sel_q)
			cache_clock_config_pkg::SRC_24M: begin
				bus_half  = half_edge[P24];
				bus_limit = `CRYSTAL_HALF_COUNT;
			end
			cache_clock_config_pkg::SRC_ALT: begin
				bus_half  = half_edge[PALT];
				bus_limit = 4'(`BUS_ALT_HALF_TABLE >> {src_q[2:0], 2'h0});
			end
			default: begin
				bus_half  = half_edge[P14];
				bus_limit = `CRYSTAL_HALF_COUNT;
			end
		endcase
	end
	assign bus_src_tick = bus_half && bus_cnt_q >= bus_limit - 4'h1;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_cnt_q <= 4'h0;
			bus_clk_q <= 1'b0;
		end else if (bus_half) begin
			if (bus_src_tick) begin
				bus_cnt_q <= 4'h0;
				bus_clk_q <= ~bus_clk_q;
			end else begin
				bus_cnt_q <= bus_cnt_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sleep divider and system clock switch

	assign sleep_div = 8'(`SLEEP_DIV_TABLE >> {sleep_q[2:0], 3'h0});
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_cnt_q <= 8'h00;
			sleep_clk_q <= 1'b0;
		end else if (bus_src_tick) begin
			if (sleep_cnt_q >= sleep_div - 8'h01) begin
				sleep_cnt_q <= 8'h00;
				sleep_clk_q <= ~sleep_clk_q;
			end else begin
				sleep_cnt_q <= sleep_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_clock_q <= 1'b0;
		end else if (sleep_q[`SLEEP_ENABLE]) begin
			sys_clock_q <= sleep_clk_q;
		end else begin
			sys_clock_q <= lvl_q[PALT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence cache_write_s;
		reg_wr && reg_addr == `OFS_CACHE_SETUP;
	endsequence
	sequence range_write_s;
		reg_wr && reg_addr == `OFS_UNCACHED_RANGE;
	endsequence
	post_write_a: assert property (
		cache_write_s |-> ##2 cache_cfg_q.post_write_en == $past(reg_wdata[7], 2))
		else $error("post write enable not taken from write");
	write_wait_a: assert property (
		cache_write_s |-> ##2
		cache_cfg_q.page_write_zero_wait == $past(reg_wdata[6], 2))
		else $error("page write wait select wrong");
	line_size_a: assert property (
		cache_cfg_q.line_size == cache_clock_config_pkg::LINE_128
		|-> $past(cache_q[2:1]) == 2'h3)
		else $error("line size 128 without pattern 11");
	strap_hold_a: assert property (
		strap_state_q == STRAP_HELD |=> $stable(strap_q))
		else $error("strap status changed after capture");
	strap_read_a: assert property (
		reg_rd && reg_addr == `OFS_POWERUP_SELECT
		|=> reg_rdata_q[7:5] == $past(strap_q) && !reg_rdata_q[4] && !reg_rdata_q[2])
		else $error("power-up status read wrong");
	refresh_div_a: assert property (
		rst_n |=> mem_cfg_q.refresh_div == (4'h1 << $past(pu_q[1:0])))
		else $error("refresh divisor decode wrong");
	base_mem_a: assert property (
		range_write_s |-> ##2 mem_cfg_q.base_512k == $past(reg_wdata[1], 2))
		else $error("base memory select not taken");
	reserved_read_a: assert property (
		reg_rd && reg_addr == `OFS_SLEEP_CONTROL |=> reg_rdata_q[7:4] == 4'h0)
		else $error("reserved sleep bits read nonzero");
	bus_clock_a: assert property (
		bus_src_tick |=> bus_clk_q != $past(bus_clk_q))
		else $error("bus clock did not toggle on source tick");
	sleep_switch_a: assert property (
		sleep_q[3] && $stable(sleep_clk_q) |=> sys_clock_q == $past(sleep_clk_q))
		else $error("system clock not on sleep clock");

endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "cache_clock_config_regs.svh"
`define CHECK(nm, exp, got) \
	begin checks++; if ((got) !== (exp)) begin bad_count++; \
	$display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module testbench;

////////////////////////////////////////////////////////////////////////////////
	localparam int H14  = 5;
	localparam int H24  = 7;
	localparam int HALT = 10;

	logic                   core_clk               = 1'b0;
	logic                   rst_n                  = 1'b0;
	logic [`ADDR_WIDTH-1:0] reg_addr               = '0;
	logic [7:0]             reg_wdata              = 8'h00;
	logic                   reg_wr                 = 1'b0;
	logic                   reg_rd                 = 1'b0;
	logic [7:0]             reg_rdata_q;
	logic                   crystal_14m_input      = 1'b0;
	logic                   crystal_24m_input      = 1'b0;
	logic                   alt_clock_source_input = 1'b0;
	logic                   strap_rom_8bit         = 1'b0;
	logic                   strap_older_cpu_mode   = 1'b0;
	logic                   strap_l1_write_back    = 1'b0;
	logic                   delay_clock_sel        = 1'b0;
	logic                   bus_clk_q;
	logic                   sys_clock_q;
	logic                   delay_tick_q;
	cache_clock_config_pkg::cache_cfg_type cache_cfg_q;
	cache_clock_config_pkg::mem_cfg_type   mem_cfg_q;
	cache_clock_config_pkg::strap_type     strap_q;
	cache_clock_config_pkg::clk_src_type   bus_src_sel_q;

	int   checks    = 0;
	int   bad_count = 0;
	int   c14       = 0;
	int   c24       = 0;
	int   calt      = 0;
	int   n_bus;
	int   n_sys;
	int   n_tick;
	logic counting  = 1'b0;
	logic bus_prev;
	logic sys_prev;

	chipset_cache_clock_config dut (
		.core_clk               (core_clk),
		.rst_n                  (rst_n),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata_q            (reg_rdata_q),
		.crystal_14m_input      (crystal_14m_input),
		.crystal_24m_input      (crystal_24m_input),
		.alt_clock_source_input (alt_clock_source_input),
		.strap_rom_8bit         (strap_rom_8bit),
		.strap_older_cpu_mode   (strap_older_cpu_mode),
		.strap_l1_write_back    (strap_l1_write_back),
		.delay_clock_sel        (delay_clock_sel),
		.cache_cfg_q            (cache_cfg_q),
		.mem_cfg_q              (mem_cfg_q),
		.strap_q                (strap_q),
		.bus_src_sel_q          (bus_src_sel_q),
		.bus_clk_q              (bus_clk_q),
		.sys_clock_q            (sys_clock_q),
		.delay_tick_q           (delay_tick_q)
	);

	always #2 core_clk = ~core_clk;

////////////////////////////////////////////////////////////////////////////////
	// Slow source pins, free running
	always @(posedge core_clk) begin
		c14 <= (c14 == H14 - 1) ? 0 : c14 + 1;
		c24 <= (c24 == H24 - 1) ? 0 : c24 + 1;
		calt <= (calt == HALT - 1) ? 0 : calt + 1;
		if (c14 == H14 - 1) crystal_14m_input <= ~crystal_14m_input;
		if (c24 == H24 - 1) crystal_24m_input <= ~crystal_24m_input;
		if (calt == HALT - 1) alt_clock_source_input <= ~alt_clock_source_input;
	end

	// Edge counters on the derived clocks
	always @(posedge core_clk) begin
		if (counting) begin
			n_bus += (bus_clk_q !== bus_prev);
			n_sys += (sys_clock_q !== sys_prev);
			n_tick += (delay_tick_q === 1'b1);
		end
		bus_prev <= bus_clk_q;
		sys_prev <= sys_clock_q;
	end

////////////////////////////////////////////////////////////////////////////////
	function automatic bit near(input int got, input int exp);
		return got >= exp - 1 && got <= exp + 1;
	endfunction

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHECK("register read", e, reg_rdata_q)
	endtask

	// Settle after a change, then count over w cycles
	task automatic measure(input int w);
		repeat (300) @(negedge core_clk);
		n_bus = 0;
		n_sys = 0;
		n_tick = 0;
		counting = 1'b1;
		repeat (w) @(negedge core_clk);
		counting = 1'b0;
	endtask

	task automatic do_reset(input logic [2:0] s);
		{strap_rom_8bit, strap_older_cpu_mode, strap_l1_write_back} <= s;
		rst_n <= 1'b0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
	endtask

////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		do_reset(3'b101);
		`CHECK("cache cfg", 8'h00, cache_cfg_q)
		`CHECK("strap", 3'b101, strap_q)
		`CHECK("source sel", 2'd0, bus_src_sel_q)
		rchk(`OFS_CACHE_SETUP, 8'h00);
		rchk(`OFS_POWERUP_SELECT, 8'hA0);
		rchk(`OFS_BUS_CLOCK_SRC, 8'h00);
		rchk(`OFS_SLEEP_CONTROL, 8'h00);
		rchk(`OFS_UNCACHED_RANGE, 8'h00);
		@(posedge core_clk);
		{strap_rom_8bit, strap_older_cpu_mode, strap_l1_write_back} <= 3'b010;
		rchk(`OFS_POWERUP_SELECT, 8'hA0);
		@(posedge core_clk);
		do_reset(3'b110);
		rchk(`OFS_POWERUP_SELECT, 8'hC0);
		wr(4'h7, 8'hFF);
		rchk(4'h7, 8'h00);
		rchk(4'hF, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_cache();
		logic [7:0] v [10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08,
			8'h02, 8'h04, 8'h06, 8'h01, 8'hFF};
		logic [1:0] ls;
		foreach (v[i]) begin
			wr(`OFS_CACHE_SETUP, v[i]);
			rchk(`OFS_CACHE_SETUP, v[i]);
			ls = (v[i][2:1] == 2'b01) ? 2'd1 : (v[i][2:1] == 2'b11) ? 2'd2 : 2'd0;
			`CHECK("cache cfg", {v[i][7:3], ls, v[i][0]}, cache_cfg_q)
		end
		$display("test cache done");
	endtask

	task automatic t_powerup();
		wr(`OFS_POWERUP_SELECT, 8'hFF);
		rchk(`OFS_POWERUP_SELECT, 8'hCB);
		`CHECK("upper rom", 1'b1, mem_cfg_q.upper_rom_from_system_bus)
		for (int c = 0; c < 4; c++) begin
			wr(`OFS_POWERUP_SELECT, 8'(c));
			rchk(`OFS_POWERUP_SELECT, 8'hC0 | 8'(c));
			`CHECK("refresh div", 4'(1 << c), mem_cfg_q.refresh_div)
		end
		`CHECK("upper rom", 1'b0, mem_cfg_q.upper_rom_from_system_bus)
		$display("test powerup done");
	endtask

	task automatic t_range();
		logic [3:0] p [6] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF, 4'h4};
		logic [2:0] n [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd0};
		foreach (p[i]) begin
			wr(`OFS_UNCACHED_RANGE, {p[i], 2'b11, 1'(i), 1'b1});
			rchk(`OFS_UNCACHED_RANGE, {p[i], 2'b00, 1'(i), 1'b0});
			`CHECK("nc limit", n[i], mem_cfg_q.nc_limit)
			`CHECK("base 512k", 1'(i), mem_cfg_q.base_512k)
		end
		$display("test range done");
	endtask

	task automatic t_bus_clock();
		int c [8] = '{4, 6, 3, 7, 2, 1, 5, 0};
		int h [8] = '{2, 2, 3, 4, 5, 6, 8, 10};
		wr(`OFS_BUS_CLOCK_SRC, 8'h08);
		repeat (2) @(negedge core_clk);
		`CHECK("source sel", 2'd0, bus_src_sel_q)
		measure(1000);
		`CHECK("bus clk 14m", 1'b1, near(n_bus, 1000 / (2 * H14)))
		wr(`OFS_BUS_CLOCK_SRC, 8'h18);
		rchk(`OFS_BUS_CLOCK_SRC, 8'h18);
		`CHECK("source sel", 2'd1, bus_src_sel_q)
		measure(1000);
		`CHECK("bus clk 24m", 1'b1, near(n_bus, 1000 / (2 * H24)))
		foreach (c[i]) begin
			wr(`OFS_BUS_CLOCK_SRC, 8'h10 | 8'(c[i]));
			repeat (2) @(negedge core_clk);
			`CHECK("source sel", 2'd2, bus_src_sel_q)
			measure(1000);
			`CHECK("bus clk alt", 1'b1, near(n_bus, 1000 / (h[i] * HALT)))
		end
		$display("test bus clock done");
	endtask

	task automatic t_delay();
		int c [8] = '{4, 5, 2, 6, 3, 0, 7, 1};
		int h [8] = '{2, 2, 3, 4, 5, 6, 8, 10};
		@(posedge core_clk);
		delay_clock_sel <= 1'b1;
		foreach (c[i]) begin
			wr(`OFS_BUS_CLOCK_SRC, {3'(c[i]), 5'h00});
			measure(1000);
			`CHECK("delay ticks", 1'b1, near(n_tick, 1000 / (h[i] * HALT)))
		end
		@(posedge core_clk);
		delay_clock_sel <= 1'b0;
		measure(1000);
		`CHECK("delay ticks off", 0, n_tick)
		$display("test delay done");
	endtask

	task automatic t_sleep();
		int c [8] = '{0, 4, 5, 6, 7, 1, 2, 3};
		int d [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
		wr(`OFS_BUS_CLOCK_SRC, 8'h00);
		wr(`OFS_SLEEP_CONTROL, 8'hFF);
		rchk(`OFS_SLEEP_CONTROL, 8'h0F);
		foreach (c[i]) begin
			wr(`OFS_SLEEP_CONTROL, 8'h08 | 8'(c[i]));
			measure(2600);
			`CHECK("sleep clk", 1'b1, near(n_sys, 2600 / (2 * H14 * d[i])))
		end
		wr(`OFS_SLEEP_CONTROL, 8'h00);
		measure(1000);
		`CHECK("sys clk awake", 1'b1, near(n_sys, 1000 / HALT))
		$display("test sleep done");
	endtask

////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		$display("watchdog expired");
		print_verdict();
	end

	initial begin
		t_reset();
		t_cache();
		t_powerup();
		t_range();
		t_bus_clock();
		t_delay();
		t_sleep();
		print_verdict();
	end

endmodule
